// >>> antc_partner.sv
// Link partner model: sends bursts of link pulses on its own link clock.
// Assumes the bench pulses go only while busy is low.
`timescale 1ns/1ps
`default_nettype none

module antc_partner #(
	parameter int unsigned GAP = 6
) (
	input wire logic go,
	input wire logic [4:0] npulse,
	output logic link_clk,
	output logic lp_in,
	output logic busy
);
	// Clock runs only inside a burst; phase offset keeps it unrelated to clk
	initial begin
		link_clk = 1'h0;
		lp_in = 1'h0;
		busy = 1'h0;
		forever begin
			wait (go);
			busy = 1'h1;
			#3.3;
			// One link edge per pulse, GAP link cycles apart, well above 4 clk periods
			// Pulse drops just after the sampling edge, never twice in one step
			repeat (npulse) begin
				lp_in = 1'h1;
				repeat (GAP) begin
					#16 link_clk = 1'h1;
					#1 lp_in = 1'h0;
					#15 link_clk = 1'h0;
				end
			end
			busy = 1'h0;
			wait (!go);
		end
	end
endmodule // antc_partner

`default_nettype wire

// >>> antc_timer.sv
// Restartable one-shot timer counting the local system clock.
// Assumes start is a clean pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module antc_timer #(
	parameter int unsigned CYC = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic start,
	output logic busy_r,
	output logic done_r,
	output logic expire_r
);
	localparam int unsigned W = (CYC > 1) ? $clog2(CYC + 1) : 1;

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic busy_nxt;
	logic done_nxt;
	wire last = busy_r && (cnt_r == W'(1));

	// Down count; a start while running simply reloads (restart)
	assign cnt_nxt = start ? W'(CYC) : (busy_r && !last) ? cnt_r - W'(1) : cnt_r;
	assign busy_nxt = start | (busy_r & ~last);
	assign done_nxt = start ? 1'b0 : (done_r | last);

	// Count state; done stays high until the next start
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			expire_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
			expire_r <= last & ~start;
		end
	end

	// Elapsed cycles since the last start, read only by the check below
	int unsigned el_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			el_r <= 0;
		end else begin
			el_r <= start ? 0 : (busy_r ? el_r + 1 : el_r);
		end
	end

	timer_len_a: assert property (@(posedge clk) disable iff (!nrst) $rose(done_r) |-> el_r == CYC)
		else $error("timer expired at the wrong count");
endmodule // antc_timer

`default_nettype wire

// >>> antc_timers.sv
// Timing constants and the timer and counter bank for the negotiation state machines.
// Assumes clk at 200 MHz, controls from logic on clk, link pulses on link_clk.
// How it works
// - Pulse-gap maximum timer expires 165 to 185 us after last link pulse.
// - Pulse-gap minimum timer expires 5 to 25 us after last link pulse.
// - Transmit interval timer expires 55.5 to 69.5 us, nominal 62.5.
// - Link-fail timer starts entering link-good-check, expires 750 to 1000 ms.
// - Link failed only when that timer expired and link still not OK.
// - No-burst timer expires 50 to 150 ms; expiry forces receive to idle.
// - Burst-to-burst minimum timer expires 5 to 7 ms after start.
// - Burst spacing timer expires 5.7 to 22.3 ms, typically 14.
// - Pulse counter 0 to 17; not done 0 to 5, done 6 to 17.
// - Extra-ack counter 0 to 8; not done to 5, done 6 to 8.
// - Only the first sixteen received data bits are kept.
// - Received-bit counter saturates at 17; not done 1-15, done 16-17, check 10-17.
// - Sent-bit counter starts at one; not done 1 to 16, done at 17.
// - Without next pages, link-good-check follows once acknowledge sending ends.
// - Wait timer expires 500 to 1000 ms after a technology reports ready.
// - Break-link timer expires 1200 to 1500 ms after being started.
// - Data-detect minimum timer expires 15 to 47 us after clock pulse.
// - Data-detect maximum timer expires 78 to 100 us after clock pulse.
`timescale 1ns/1ps
`default_nettype none

package antc_pkg;
	localparam int unsigned CLK_NS = 5;
	// Window bounds in ns; the cycle count sits at the middle or typical point
	localparam int unsigned FLP_MAX_LO_NS = 165_000;
	localparam int unsigned FLP_MAX_HI_NS = 185_000;
	localparam int unsigned FLP_MAX_CYC = (FLP_MAX_LO_NS / 2 + FLP_MAX_HI_NS / 2) / CLK_NS;
	localparam int unsigned FLP_MIN_LO_NS = 5_000;
	localparam int unsigned FLP_MIN_HI_NS = 25_000;
	localparam int unsigned FLP_MIN_CYC = (FLP_MIN_LO_NS / 2 + FLP_MIN_HI_NS / 2) / CLK_NS;
	localparam int unsigned INTV_TYP_NS = 62_500;
	localparam int unsigned INTV_CYC = INTV_TYP_NS / CLK_NS;
	localparam int unsigned LFI_LO_NS = 750_000_000;
	localparam int unsigned LFI_HI_NS = 1_000_000_000;
	localparam int unsigned LFI_CYC = (LFI_LO_NS / 2 + LFI_HI_NS / 2) / CLK_NS;
	localparam int unsigned NLP_MAX_LO_NS = 50_000_000;
	localparam int unsigned NLP_MAX_HI_NS = 150_000_000;
	localparam int unsigned NLP_MAX_CYC = (NLP_MAX_LO_NS / 2 + NLP_MAX_HI_NS / 2) / CLK_NS;
	localparam int unsigned NLP_MIN_LO_NS = 5_000_000;
	localparam int unsigned NLP_MIN_HI_NS = 7_000_000;
	localparam int unsigned NLP_MIN_CYC = (NLP_MIN_LO_NS / 2 + NLP_MIN_HI_NS / 2) / CLK_NS;
	localparam int unsigned BURST_TYP_NS = 14_000_000;
	localparam int unsigned BURST_CYC = BURST_TYP_NS / CLK_NS;
	localparam int unsigned WAIT_LO_NS = 500_000_000;
	localparam int unsigned WAIT_HI_NS = 1_000_000_000;
	localparam int unsigned WAIT_CYC = (WAIT_LO_NS / 2 + WAIT_HI_NS / 2) / CLK_NS;
	localparam int unsigned BRK_LO_NS = 1_200_000_000;
	localparam int unsigned BRK_HI_NS = 1_500_000_000;
	localparam int unsigned BRK_CYC = (BRK_LO_NS / 2 + BRK_HI_NS / 2) / CLK_NS;
	localparam int unsigned DD_MIN_LO_NS = 15_000;
	localparam int unsigned DD_MIN_HI_NS = 47_000;
	localparam int unsigned DD_MIN_CYC = (DD_MIN_LO_NS / 2 + DD_MIN_HI_NS / 2) / CLK_NS;
	localparam int unsigned DD_MAX_LO_NS = 78_000;
	localparam int unsigned DD_MAX_HI_NS = 100_000;
	localparam int unsigned DD_MAX_CYC = (DD_MAX_LO_NS / 2 + DD_MAX_HI_NS / 2) / CLK_NS;
	// Counter limits and decode points
	localparam logic [4:0] FLP_CNT_MAX = 5'h11;
	localparam logic [4:0] FLP_DONE_MIN = 5'h06;
	localparam logic [3:0] ACK_CNT_MAX = 4'h8;
	localparam logic [3:0] ACK_DONE_MIN = 4'h6;
	localparam logic [4:0] RXB_CNT_MAX = 5'h11;
	localparam logic [4:0] RXB_NOT_DONE_MIN = 5'h01;
	localparam logic [4:0] RXB_DONE_MIN = 5'h10;
	localparam logic [4:0] RXB_CHECK_MIN = 5'h0A;
	localparam logic [4:0] TXB_INIT = 5'h01;
	localparam logic [4:0] TXB_DONE = 5'h11;
	localparam int unsigned WORD_BITS = 16;
	localparam int unsigned NUM_TECH = 3;
endpackage

module antc_timers #(
	parameter int unsigned FLP_MAX_CYC = antc_pkg::FLP_MAX_CYC,
	parameter int unsigned INTV_CYC = antc_pkg::INTV_CYC,
	parameter int unsigned LFI_CYC = antc_pkg::LFI_CYC,
	parameter int unsigned NLP_MAX_CYC = antc_pkg::NLP_MAX_CYC,
	parameter int unsigned NLP_MIN_CYC = antc_pkg::NLP_MIN_CYC,
	parameter int unsigned BURST_CYC = antc_pkg::BURST_CYC,
	parameter int unsigned WAIT_CYC = antc_pkg::WAIT_CYC,
	parameter int unsigned BRK_CYC = antc_pkg::BRK_CYC,
	parameter int unsigned DD_MIN_CYC = antc_pkg::DD_MIN_CYC,
	parameter int unsigned DD_MAX_CYC = antc_pkg::DD_MAX_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic link_clk,
	input wire logic lp_in,
	input wire logic lgc_enter,
	input wire logic nlp_max_start,
	input wire logic nlp_min_start,
	input wire logic intv_start,
	input wire logic burst_start,
	input wire logic brk_start,
	input wire logic [antc_pkg::NUM_TECH-1:0] tech_ready,
	input wire logic link_ok,
	input wire logic ack_finished,
	input wire logic np_supported,
	input wire logic np_cond,
	input wire logic flp_init,
	input wire logic flp_inc,
	input wire logic ack_init,
	input wire logic ack_inc,
	input wire logic rxb_init,
	input wire logic rxb_inc,
	input wire logic rx_data_bit,
	input wire logic txb_init,
	input wire logic txb_inc,
	output logic link_pulse_r,
	output logic flp_max_done,
	output logic flp_min_done,
	output logic intv_done,
	output logic lfi_done,
	output logic nlp_max_done,
	output logic rx_force_idle,
	output logic nlp_min_done,
	output logic burst_done,
	output logic wait_done,
	output logic brk_done,
	output logic dd_min_done,
	output logic dd_max_done,
	output logic link_failed_r,
	output logic lgc_go_r,
	output logic flp_not_done_r,
	output logic flp_done_r,
	output logic ack_not_done_r,
	output logic ack_done_r,
	output logic rxb_not_done_r,
	output logic rxb_done_r,
	output logic rxb_check_r,
	output logic [antc_pkg::WORD_BITS-1:0] rx_word_r,
	output logic txb_not_done_r,
	output logic txb_done_r
);
	// Link side: each received pulse flips a toggle, so a stopped link clock is harmless
	logic lp_tog_r;
	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			lp_tog_r <= 1'b0;
		end else begin
			lp_tog_r <= lp_tog_r ^ lp_in;
		end
	end

	// Toggle crossing into clk; the second and third stages feed the edge compare
	logic tog_s1_r;
	logic tog_s2_r;
	logic tog_s3_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tog_s1_r <= 1'b0;
			tog_s2_r <= 1'b0;
			tog_s3_r <= 1'b0;
			link_pulse_r <= 1'b0;
		end else begin
			tog_s1_r <= lp_tog_r;
			tog_s2_r <= tog_s1_r;
			tog_s3_r <= tog_s2_r;
			link_pulse_r <= tog_s2_r ^ tog_s3_r;
		end
	end

	// Any technology turning ready starts the parallel-detection wait
	logic [antc_pkg::NUM_TECH-1:0] ready_q_r;
	wire wait_start = |(tech_ready & ~ready_q_r);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ready_q_r <= '0;
		end else begin
			ready_q_r <= tech_ready;
		end
	end

	// Pulse-gap and data-detect timers all restart on each received pulse
	antc_timer #(.CYC(FLP_MAX_CYC)) u_flp_max (
		.clk(clk), .nrst(nrst), .start(link_pulse_r),
		.busy_r(), .done_r(flp_max_done), .expire_r());
	antc_timer #(.CYC(antc_pkg::FLP_MIN_CYC)) u_flp_min (
		.clk(clk), .nrst(nrst), .start(link_pulse_r),
		.busy_r(), .done_r(flp_min_done), .expire_r());
	antc_timer #(.CYC(DD_MIN_CYC)) u_dd_min (
		.clk(clk), .nrst(nrst), .start(link_pulse_r),
		.busy_r(), .done_r(dd_min_done), .expire_r());
	antc_timer #(.CYC(DD_MAX_CYC)) u_dd_max (
		.clk(clk), .nrst(nrst), .start(link_pulse_r),
		.busy_r(), .done_r(dd_max_done), .expire_r());
	antc_timer #(.CYC(INTV_CYC)) u_intv (
		.clk(clk), .nrst(nrst), .start(intv_start),
		.busy_r(), .done_r(intv_done), .expire_r());
	logic lfi_busy;
	antc_timer #(.CYC(LFI_CYC)) u_lfi (
		.clk(clk), .nrst(nrst), .start(lgc_enter),
		.busy_r(lfi_busy), .done_r(lfi_done), .expire_r());
	// Expiry pulse of the no-burst timer is the receive idle force
	antc_timer #(.CYC(NLP_MAX_CYC)) u_nlp_max (
		.clk(clk), .nrst(nrst), .start(nlp_max_start),
		.busy_r(), .done_r(nlp_max_done), .expire_r(rx_force_idle));
	antc_timer #(.CYC(NLP_MIN_CYC)) u_nlp_min (
		.clk(clk), .nrst(nrst), .start(nlp_min_start),
		.busy_r(), .done_r(nlp_min_done), .expire_r());
	antc_timer #(.CYC(BURST_CYC)) u_burst (
		.clk(clk), .nrst(nrst), .start(burst_start),
		.busy_r(), .done_r(burst_done), .expire_r());
	antc_timer #(.CYC(WAIT_CYC)) u_wait (
		.clk(clk), .nrst(nrst), .start(wait_start),
		.busy_r(), .done_r(wait_done), .expire_r());
	antc_timer #(.CYC(BRK_CYC)) u_brk (
		.clk(clk), .nrst(nrst), .start(brk_start),
		.busy_r(), .done_r(brk_done), .expire_r());

	// Link qualification and the simplified path into link-good-check
	wire link_failed_nxt = lfi_done & ~link_ok;
	wire lgc_go_nxt = ack_finished & (~np_supported | np_cond);

	// Counter next values; init wins over increment, all saturate
	logic [4:0] flp_cnt_r;
	logic [3:0] ack_cnt_r;
	logic [4:0] rxb_cnt_r;
	logic [4:0] txb_cnt_r;
	wire [4:0] flp_cnt_nxt = flp_init ? 5'h00 :
		(flp_inc && flp_cnt_r < antc_pkg::FLP_CNT_MAX) ? flp_cnt_r + 5'h01 : flp_cnt_r;
	wire [3:0] ack_cnt_nxt = ack_init ? 4'h0 :
		(ack_inc && ack_cnt_r < antc_pkg::ACK_CNT_MAX) ? ack_cnt_r + 4'h1 : ack_cnt_r;
	wire [4:0] rxb_cnt_nxt = rxb_init ? 5'h00 :
		(rxb_inc && rxb_cnt_r < antc_pkg::RXB_CNT_MAX) ? rxb_cnt_r + 5'h01 : rxb_cnt_r;
	wire [4:0] txb_cnt_nxt = txb_init ? antc_pkg::TXB_INIT :
		(txb_inc && txb_cnt_r < antc_pkg::TXB_DONE) ? txb_cnt_r + 5'h01 : txb_cnt_r;

	// Bits past the sixteenth come from stray pulses and are dropped
	wire rx_keep = rxb_inc && !rxb_init && (rxb_cnt_r < antc_pkg::RXB_DONE_MIN);
	wire [15:0] rx_sel = 16'h0001 << rxb_cnt_r[3:0];
	wire [15:0] rx_word_nxt = rx_keep ?
		((rx_word_r & ~rx_sel) | (rx_sel & {16{rx_data_bit}})) : rx_word_r;

	// Counters and qualification flags
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flp_cnt_r <= 5'h00;
			ack_cnt_r <= 4'h0;
			rxb_cnt_r <= 5'h00;
			txb_cnt_r <= antc_pkg::TXB_INIT;
			rx_word_r <= 16'h0000;
			link_failed_r <= 1'b0;
			lgc_go_r <= 1'b0;
		end else begin
			flp_cnt_r <= flp_cnt_nxt;
			ack_cnt_r <= ack_cnt_nxt;
			rxb_cnt_r <= rxb_cnt_nxt;
			txb_cnt_r <= txb_cnt_nxt;
			rx_word_r <= rx_word_nxt;
			link_failed_r <= link_failed_nxt;
			lgc_go_r <= lgc_go_nxt;
		end
	end

	// Flags decoded from the next count so they line up with the count itself
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flp_not_done_r <= 1'b1;
			flp_done_r <= 1'b0;
			ack_not_done_r <= 1'b1;
			ack_done_r <= 1'b0;
			rxb_not_done_r <= 1'b0;
			rxb_done_r <= 1'b0;
			rxb_check_r <= 1'b0;
			txb_not_done_r <= 1'b1;
			txb_done_r <= 1'b0;
		end else begin
			flp_not_done_r <= flp_cnt_nxt < antc_pkg::FLP_DONE_MIN;
			flp_done_r <= flp_cnt_nxt >= antc_pkg::FLP_DONE_MIN;
			ack_not_done_r <= ack_cnt_nxt < antc_pkg::ACK_DONE_MIN;
			ack_done_r <= ack_cnt_nxt >= antc_pkg::ACK_DONE_MIN;
			rxb_not_done_r <= (rxb_cnt_nxt >= antc_pkg::RXB_NOT_DONE_MIN) &&
				(rxb_cnt_nxt < antc_pkg::RXB_DONE_MIN);
			rxb_done_r <= rxb_cnt_nxt >= antc_pkg::RXB_DONE_MIN;
			rxb_check_r <= rxb_cnt_nxt >= antc_pkg::RXB_CHECK_MIN;
			txb_not_done_r <= txb_cnt_nxt < antc_pkg::TXB_DONE;
			txb_done_r <= txb_cnt_nxt == antc_pkg::TXB_DONE;
		end
	end

	// Checks on the decoded behaviour
	pulse_gap_a: assert property (@(posedge clk) disable iff (!nrst) link_pulse_r |=> !flp_max_done && !flp_min_done ##1 !flp_max_done)
		else $error("pulse gap timers not restarted by a link pulse");
	data_detect_a: assert property (@(posedge clk) disable iff (!nrst) link_pulse_r |=> !dd_min_done && !dd_max_done)
		else $error("data detect timers not restarted by a link pulse");
	lfi_start_a: assert property (@(posedge clk) disable iff (!nrst) lgc_enter |=> lfi_busy && !lfi_done)
		else $error("link fail timer not started on entry");
	fail_qual_a: assert property (@(posedge clk) disable iff (!nrst) link_failed_r == $past(lfi_done && !link_ok))
		else $error("link failed flag not qualified by timer and status");
	force_idle_a: assert property (@(posedge clk) disable iff (!nrst) rx_force_idle |-> nlp_max_done && !$past(nlp_max_done))
		else $error("idle force without fresh no-burst expiry");
	pulse_flags_a: assert property (@(posedge clk) disable iff (!nrst) flp_done_r == (flp_cnt_r >= 5'h06) && flp_not_done_r != flp_done_r && flp_cnt_r <= 5'h11)
		else $error("pulse counter flags wrong");
	ack_flags_a: assert property (@(posedge clk) disable iff (!nrst) ack_cnt_r <= 4'h8 && ack_done_r == (ack_cnt_r >= 4'h6))
		else $error("extra ack counter out of range");
	rx_keep_a: assert property (@(posedge clk) disable iff (!nrst) rxb_cnt_r >= 5'h10 && !rxb_init |=> $stable(rx_word_r))
		else $error("bit beyond the sixteenth was stored");
	rx_sat_a: assert property (@(posedge clk) disable iff (!nrst) rxb_cnt_r == 5'h11 && !rxb_init |=> rxb_cnt_r == 5'h11 && rxb_done_r && rxb_check_r)
		else $error("received bit counter did not saturate");
	tx_init_a: assert property (@(posedge clk) disable iff (!nrst) txb_init |=> txb_cnt_r == 5'h01 && txb_not_done_r && !txb_done_r)
		else $error("sent bit counter not initialised to one");
	lgc_path_a: assert property (@(posedge clk) disable iff (!nrst) !np_supported && ack_finished |=> lgc_go_r)
		else $error("link good check not allowed after acknowledge");
	wait_start_a: assert property (@(posedge clk) disable iff (!nrst)
		(tech_ready & ~$past(tech_ready)) != '0 |=> ##1 !wait_done)
		else $error("wait timer not started by ready");

	flp_done_c: cover property (@(posedge clk) disable iff (!nrst) $rose(flp_done_r));
	force_idle_c: cover property (@(posedge clk) disable iff (!nrst) rx_force_idle);
	link_fail_c: cover property (@(posedge clk) disable iff (!nrst) $rose(link_failed_r));
	rx_sat_c: cover property (@(posedge clk) disable iff (!nrst) rxb_cnt_r == 5'h11);
endmodule // antc_timers

`default_nettype wire

// >>> autoneg_timers_counters_bench.sv
// Self-checking bench for the negotiation timer and counter bank.
// Assumes shortened timer parameters; expected values wait in a queue until due.
`timescale 1ns/1ps
`default_nettype none

module autoneg_timers_counters_bench;
	typedef struct {int unsigned due; int sel; logic [31:0] exp; string nm;} antc_note_s;
	// Order: interval, fail, no-burst, burst gap, spacing, wait, break, pulse max/min, data min/max
	localparam int unsigned TC [0:10] = '{20, 40, 30, 25, 35, 45, 50, 60, 3000, 24, 48};
	logic clk = 1'h0;
	logic nrst;
	logic go = 1'h0;
	logic [4:0] npulse = 5'h01;
	logic [5:0] st = '0;
	logic [2:0] tr = '0;
	logic link_ok = 1'h0;
	logic [2:0] ack_np = '0;
	logic rx_bit = 1'h0;
	logic [3:0] ci = '0;
	logic [3:0] cn = '0;
	logic lpr, fmax, fmin, intv, lfi, nmax, fi, nmin, brst, wt, brk, ddmn, ddmx, lfail, lgo;
	wire [1:0] ff, af, tf;
	wire [2:0] rf;
	wire [15:0] word;
	logic [15:0] rxw = '0; // Init leaves the stored word alone, so it carries across runs
	logic link_clk, lp_in, busy;
	wire [10:0] tdn = {ddmx, ddmn, fmin, fmax, brk, wt, brst, nmin, nmax, lfi, intv};
	int unsigned cyc = 0;
	int unsigned fi_cnt = 0;
	int unsigned lp_cnt = 0;
	int err_count = 0;
	int tests_run = 0;
	int seed = 84;
	antc_note_s q[$];

	antc_timers #(.FLP_MAX_CYC(TC[7]), .INTV_CYC(TC[0]), .LFI_CYC(TC[1]), .NLP_MAX_CYC(TC[2]),
		.NLP_MIN_CYC(TC[3]), .BURST_CYC(TC[4]), .WAIT_CYC(TC[5]), .BRK_CYC(TC[6]),
		.DD_MIN_CYC(TC[9]), .DD_MAX_CYC(TC[10])) i_dut (.clk(clk), .nrst(nrst),
		.link_clk(link_clk), .lp_in(lp_in), .lgc_enter(st[1]), .nlp_max_start(st[2]),
		.nlp_min_start(st[3]), .intv_start(st[0]), .burst_start(st[4]), .brk_start(st[5]),
		.tech_ready(tr), .link_ok(link_ok), .ack_finished(ack_np[2]), .np_supported(ack_np[1]),
		.np_cond(ack_np[0]), .flp_init(ci[0]), .flp_inc(cn[0]), .ack_init(ci[1]), .ack_inc(cn[1]),
		.rxb_init(ci[2]), .rxb_inc(cn[2]), .rx_data_bit(rx_bit), .txb_init(ci[3]), .txb_inc(cn[3]),
		.link_pulse_r(lpr), .flp_max_done(fmax), .flp_min_done(fmin), .intv_done(intv),
		.lfi_done(lfi), .nlp_max_done(nmax), .rx_force_idle(fi), .nlp_min_done(nmin),
		.burst_done(brst), .wait_done(wt), .brk_done(brk), .dd_min_done(ddmn), .dd_max_done(ddmx),
		.link_failed_r(lfail), .lgc_go_r(lgo), .flp_not_done_r(ff[1]), .flp_done_r(ff[0]),
		.ack_not_done_r(af[1]), .ack_done_r(af[0]), .rxb_not_done_r(rf[2]), .rxb_done_r(rf[1]),
		.rxb_check_r(rf[0]), .rx_word_r(word), .txb_not_done_r(tf[1]), .txb_done_r(tf[0]));

	antc_partner #(.GAP(6)) i_partner (.go(go), .npulse(npulse), .link_clk(link_clk),
		.lp_in(lp_in), .busy(busy));

	// Clock, cycle count and pulse tallies
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		fi_cnt <= nrst ? fi_cnt + fi : 0; // Cleared in reset so unknowns never accumulate
		lp_cnt <= nrst ? lp_cnt + lpr : 0;
	end

	function automatic logic [31:0] obs(input int sel);
		case (sel)
			11: obs = {31'h0, lfail};
			12: obs = {31'h0, lgo};
			13: obs = {30'h0, ff};
			14: obs = {30'h0, af};
			15: obs = {29'h0, rf};
			16: obs = {30'h0, tf};
			17: obs = {16'h0, word};
			18: obs = fi_cnt;
			19: obs = lp_cnt;
			20: obs = {21'h0, tdn};
			21: obs = {31'h0, lpr};
			default: obs = {31'h0, tdn[sel]};
		endcase
	endfunction

	function automatic logic [31:0] flags(input int id, input int c);
		case (id)
			0, 1: flags = {30'h0, c <= 5, c >= 6};
			2: flags = {29'h0, c >= 1 && c <= 15, c >= 16, c >= 10};
			default: flags = {30'h0, c <= 16, c >= 17};
		endcase
	endfunction

	task automatic note(input int d, input int sel, input logic [31:0] e, input string nm);
		q.push_back('{cyc + d, sel, e, nm});
	endtask

	// Done low one cycle before expiry and high one cycle after
	task automatic texp(input int i);
		note(TC[i], i, 0, $sformatf("timer %0d early", i));
		note(TC[i] + 2, i, 1, $sformatf("timer %0d expiry", i));
	endtask

	// Notes are pushed in due order; the oldest is compared once its cycle arrives
	always @(negedge clk) begin
		while (q.size() > 0 && q[0].due <= cyc) begin
			tests_run++;
			if (obs(q[0].sel) !== q[0].exp) begin
				err_count++;
				$display("wrong value %s expected %0h seen %0h", q[0].nm, q[0].exp, obs(q[0].sel));
			end
			void'(q.pop_front());
		end
	end

	task automatic fin(input string nm);
		for (int n = 0; n < 4000 && q.size() > 0; n++) @(negedge clk);
		if (q.size() > 0) begin
			err_count++;
			$display("wrong value %s queue expected 0 seen %0d", nm, q.size());
			q.delete();
		end
		$display("test %s done", nm);
	endtask

	// Start edge is the next rising edge; one cycle of slack either side of expiry
	task automatic tstart(input int i);
		logic [31:0] r;
		@(negedge clk);
		r = $random(seed);
		if (i == 5) tr[r % 3] = 1'h1;
		else st[i == 6 ? 5 : i] = 1'h1;
		texp(i);
		@(negedge clk);
		st = '0;
		tr = '0;
	endtask

	task automatic cnt_run(input int id, input int n);
		int c;
		int mx;
		logic [31:0] r;
		mx = (id == 1) ? 8 : 17;
		c = (id == 3) ? 1 : 0;
		@(negedge clk);
		ci[id] = 1'h1;
		note(1, 13 + id, flags(id, c), "counter flags");
		repeat (n) begin
			@(negedge clk);
			ci = '0;
			cn[id] = 1'h1;
			r = $random(seed);
			rx_bit = r[0];
			if (id == 2 && c < 16) rxw[c] = r[0];
			if (c < mx) c++;
			note(1, 13 + id, flags(id, c), "counter flags");
		end
		@(negedge clk);
		cn = '0;
		if (id == 2) note(1, 17, {16'h0, rxw}, "rx word");
		fin("counter");
	endtask

	task automatic send(input int n);
		for (int k = 0; k < 200 && busy; k++) @(negedge clk);
		npulse = n[4:0];
		go = 1'h1;
		@(negedge clk);
		go = 1'h0;
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		#1 nrst = 1'h0; // Falling edge resets both clock domains
		repeat (16) @(negedge clk);
		nrst = 1'h1;
		note(1, 20, 0, "timer dones");
		note(1, 13, 2, "flp flags");
		note(1, 14, 2, "ack flags");
		note(1, 15, 0, "rx flags");
		note(1, 16, 2, "tx flags");
		fin("reset");
		for (int i = 0; i < 7; i++) begin
			tstart(i);
			fin("timer");
		end
		note(1, 18, 1, "idle force count");
		// Failure needs expiry with status not OK; restart clears it
		@(negedge clk);
		note(1, 11, 1, "link failed");
		@(negedge clk);
		link_ok = 1'h1;
		note(1, 11, 0, "link failed");
		@(negedge clk);
		link_ok = 1'h0;
		st[1] = 1'h1;
		note(2, 11, 0, "link failed");
		note(TC[1] + 3, 11, 1, "link failed");
		@(negedge clk);
		st = '0;
		fin("link fail");
		for (int i = 0; i < 8; i++) begin
			@(negedge clk);
			ack_np = i[2:0];
			note(1, 12, {31'h0, i[2] & (!i[1] | i[0])}, "good check go");
		end
		fin("good check");
		cnt_run(0, 18);
		cnt_run(1, 9);
		cnt_run(2, 18);
		cnt_run(2, 11);
		cnt_run(3, 17);
		send(1);
		for (int k = 0; k < 200 && !lpr; k++) @(negedge clk);
		if (!lpr) begin
			err_count++;
			$display("wrong value link pulse expected 1 seen 0");
		end
		note(1, 21, 0, "pulse width");
		// Pushed in order of due cycle
		texp(9);
		texp(10);
		texp(7);
		texp(8);
		fin("single pulse");
		send(3);
		repeat (200) @(negedge clk);
		note(1, 19, 4, "pulse count");
		fin("burst");
		end_of_test();
	end

	// Hang guard sized well above the longest timer in this run
	initial begin
		#100000;
		err_count++;
		$display("watchdog expired");
		end_of_test();
	end
endmodule // autoneg_timers_counters_bench

`default_nettype wire
